// ### afc_host.sv
`timescale 1ns/1ps
`default_nettype none
module afc_host (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // device pins
  output var afc_pkg::afc_pins_s devPins,
  input wire logic [afc_pkg::DATA_W-1:0] egressBus,
  input wire afc_pkg::afc_flags_s devFlags
);

  // ==========================================================
  // state
  typedef struct packed {
    afc_pkg::afc_seq_e seq;
    afc_pkg::afc_op_e op;
    logic [3:0] cnt;
    logic [1:0] ctrl;
    logic [afc_pkg::DATA_W-1:0] wdata;
    logic [afc_pkg::DATA_W-1:0] rdata;
    logic rdValid;
    logic refused;
    logic answer;
    logic [31:0] rdOut;
    afc_pkg::afc_pins_s pins;
  } afc_host_s;

  afc_host_s st;
  afc_host_s next_st;
  logic [2:0] flagsSync;
  logic emptyN;
  logic fullN;
  logic halfN;
  logic busCycle;
  logic [3:0] cmdBits;
  logic leadIdleN;

  afc_sync #(
    .W(3)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pinIn({devFlags.emptyFlagN, devFlags.fullFlagN, devFlags.halfLevelFlagN}),
    .pinOut(flagsSync)
  );

  assign emptyN = flagsSync[2];
  assign fullN = flagsSync[1];
  assign halfN = flagsSync[0];
  assign busCycle = (avsRead || avsWrite) && !st.answer;
  assign cmdBits = avsWriteData[3:0];
  // in single mode the pin is the replay input, so it must idle high there
  assign leadIdleN = st.ctrl[afc_pkg::CTRL_CHAIN_IN] ? st.ctrl[afc_pkg::CTRL_LEAD] : 1'b1;

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.answer = 1'b0;
    next_st.pins.chainInN = st.ctrl[afc_pkg::CTRL_CHAIN_IN];
    // a replay pulse is held for its full width, not only its first cycle
    if (st.seq != afc_pkg::SEQ_LOW) begin
      next_st.pins.leadOrReplayN = leadIdleN;
    end
    unique case (st.seq)
      afc_pkg::SEQ_IDLE: begin
        if (busCycle && avsWrite) begin
          unique case (avsAddress)
            afc_pkg::REG_CTRL: begin
              next_st.ctrl = avsWriteData[1:0];
              next_st.answer = 1'b1;
            end
            afc_pkg::REG_WDATA: begin
              next_st.wdata = avsWriteData[afc_pkg::DATA_W-1:0];
              next_st.answer = 1'b1;
            end
            afc_pkg::REG_CMD: begin
              next_st.answer = 1'b1;
              next_st.cnt = afc_pkg::STROBE_LOW_CYC;
              if (cmdBits[afc_pkg::CMD_RESET]) begin
                // both strobes stay high around the reset edge
                next_st.op = afc_pkg::OP_RESET;
                next_st.seq = afc_pkg::SEQ_LOW;
                next_st.pins.masterResetN = 1'b0;
                next_st.cnt = afc_pkg::RESET_LOW_CYC;
                next_st.rdValid = 1'b0;
              end else if (cmdBits[afc_pkg::CMD_REPLAY]) begin
                next_st.op = afc_pkg::OP_REPLAY;
                next_st.seq = afc_pkg::SEQ_LOW;
                next_st.pins.leadOrReplayN = 1'b0;
              end else if (cmdBits[afc_pkg::CMD_PUSH]) begin
                if (fullN) begin
                  next_st.op = afc_pkg::OP_PUSH;
                  next_st.seq = afc_pkg::SEQ_LOW;
                  next_st.pins.pushStrobeN = 1'b0;
                  next_st.pins.ingressBus = st.wdata;
                  next_st.pins.ingressOe = 1'b1;
                end else begin
                  next_st.refused = 1'b1;
                end
              end else if (cmdBits[afc_pkg::CMD_POP]) begin
                if (emptyN) begin
                  next_st.op = afc_pkg::OP_POP;
                  next_st.seq = afc_pkg::SEQ_LOW;
                  next_st.pins.popStrobeN = 1'b0;
                  next_st.cnt = afc_pkg::ACCESS_CYC;
                end else begin
                  next_st.refused = 1'b1;
                end
              end
            end
            default: begin
              next_st.answer = 1'b1;
            end
          endcase
        end else if (busCycle && avsRead) begin
          next_st.answer = 1'b1;
          unique case (avsAddress)
            afc_pkg::REG_CTRL: next_st.rdOut = {30'h0, st.ctrl};
            afc_pkg::REG_WDATA: next_st.rdOut = {23'h0, st.wdata};
            afc_pkg::REG_RDATA: begin
              next_st.rdOut = {23'h0, st.rdata};
              next_st.rdValid = 1'b0;
            end
            afc_pkg::REG_STATUS: begin
              next_st.rdOut = {26'h0, st.refused, st.rdValid, !halfN, !fullN, !emptyN, 1'b0};
              next_st.refused = 1'b0;
            end
            default: next_st.rdOut = 32'h0;
          endcase
        end
      end
      afc_pkg::SEQ_LOW: begin
        if (st.cnt > 4'h1) begin
          next_st.cnt = st.cnt - 4'h1;
        end else begin
          // pop data is sampled while the strobe is still low
          if (st.op == afc_pkg::OP_POP) begin
            next_st.rdata = egressBus;
            next_st.rdValid = 1'b1;
          end
          // rising edge of push stores the word
          next_st.pins.pushStrobeN = 1'b1;
          next_st.pins.popStrobeN = 1'b1;
          next_st.pins.masterResetN = 1'b1;
          next_st.pins.leadOrReplayN = leadIdleN;
          next_st.seq = afc_pkg::SEQ_RECOVER;
          next_st.cnt = afc_pkg::STROBE_HIGH_CYC;
        end
      end
      afc_pkg::SEQ_RECOVER: begin
        // data held past the rising push edge for hold time
        if (st.cnt > 4'h1) begin
          next_st.cnt = st.cnt - 4'h1;
        end else begin
          next_st.pins.ingressOe = 1'b0;
          next_st.seq = afc_pkg::SEQ_IDLE;
        end
      end
      default: next_st.seq = afc_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.seq <= afc_pkg::SEQ_IDLE;
      st.op <= afc_pkg::OP_PUSH;
      st.ctrl <= afc_pkg::CTRL_RESET;
      st.pins <= '1;
      st.pins.chainInN <= 1'b0;
      st.pins.leadOrReplayN <= 1'b1;
      st.pins.ingressBus <= '0;
      st.pins.ingressOe <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs; new commands stall while a strobe sequence runs
  assign devPins = st.pins;
  assign avsReadData = st.rdOut;
  assign avsWaitRequest = (avsRead || avsWrite) && !st.answer;

  // ==========================================================
  // named steps of the strobe pulses
  // repeats above eight are split so the tools need not unroll long runs
  sequence s_pop_pulse;
    !st.pins.popStrobeN [*8] ##1 !st.pins.popStrobeN [*2] ##1 st.pins.popStrobeN;
  endsequence

  sequence s_reset_pulse;
    !st.pins.masterResetN [*8] ##1 !st.pins.masterResetN [*2] ##1 st.pins.masterResetN;
  endsequence

  sequence s_replay_pulse;
    !st.pins.leadOrReplayN [*8] ##1 st.pins.leadOrReplayN;
  endsequence

  // data keeps driving through the recovery time after the rising push edge
  sequence s_data_hold;
    st.pins.ingressOe [*5] ##1 !st.pins.ingressOe;
  endsequence

  // ==========================================================
  // assertions
  a_push_not_full: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(st.pins.pushStrobeN) |-> $past(fullN))
    else $error("push started while full");

  a_pop_not_empty: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(st.pins.popStrobeN) |-> $past(emptyN))
    else $error("pop started while empty");

  a_strobe_excl: assert property (@(posedge clk_sys) disable iff (!nrst)
    !st.pins.masterResetN |-> st.pins.pushStrobeN && st.pins.popStrobeN)
    else $error("strobe low during reset");

  a_push_low_len: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(st.pins.pushStrobeN) |-> !st.pins.pushStrobeN [*8] ##1 st.pins.pushStrobeN)
    else $error("push low width wrong");

  a_data_stable: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(st.pins.pushStrobeN) |-> st.pins.ingressOe && $stable(st.pins.ingressBus))
    else $error("ingress data moved at push edge");

  a_pop_capture: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(st.pins.popStrobeN) |-> st.rdValid && st.rdata == $past(egressBus))
    else $error("pop data not captured");

  a_replay_len: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(st.pins.leadOrReplayN) && st.ctrl[afc_pkg::CTRL_CHAIN_IN] == 1'b0 |->
    s_replay_pulse)
    else $error("replay pulse width wrong");

  a_reset_len: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(st.pins.masterResetN) |-> s_reset_pulse)
    else $error("reset pulse length wrong");

  a_answer_once: assert property (@(posedge clk_sys) disable iff (!nrst)
    st.answer |=> !st.answer)
    else $error("bus answered twice");

  a_pop_low_len: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(st.pins.popStrobeN) |-> s_pop_pulse)
    else $error("pop low width wrong");

  a_data_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(st.pins.pushStrobeN) |-> s_data_hold)
    else $error("ingress data released too early");

  a_push_drives: assert property (@(posedge clk_sys) disable iff (!nrst)
    !st.pins.pushStrobeN |-> st.pins.ingressOe)
    else $error("push low with data not driven");

  a_replay_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    !st.pins.leadOrReplayN && !st.pins.chainInN |-> st.pins.pushStrobeN && st.pins.popStrobeN)
    else $error("strobe low during replay");

  a_lead_level: assert property (@(posedge clk_sys) disable iff (!nrst)
    st.pins.chainInN && st.seq == afc_pkg::SEQ_IDLE |->
    st.pins.leadOrReplayN == $past(st.ctrl[afc_pkg::CTRL_LEAD]))
    else $error("lead level not from control");

  a_chain_follow: assert property (@(posedge clk_sys) disable iff (!nrst)
    st.pins.chainInN == $past(st.ctrl[afc_pkg::CTRL_CHAIN_IN]))
    else $error("chain-in level not from control");

  a_idle_strobes: assert property (@(posedge clk_sys) disable iff (!nrst)
    st.seq == afc_pkg::SEQ_IDLE |->
    st.pins.pushStrobeN && st.pins.popStrobeN && st.pins.masterResetN)
    else $error("strobe left low in idle");

endmodule
`default_nettype wire

// ### afc_pkg.sv
package afc_pkg;

  // ==========================================================
  // register map of the controller (Avalon-MM word addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_WDATA = 4'h1;
  localparam logic [3:0] REG_RDATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_CMD = 4'h4;

  // ==========================================================
  // field positions
  localparam int CTRL_CHAIN_IN = 0;
  localparam int CTRL_LEAD = 1;
  localparam int CMD_PUSH = 0;
  localparam int CMD_POP = 1;
  localparam int CMD_RESET = 2;
  localparam int CMD_REPLAY = 3;
  localparam int ST_BUSY = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_FULL = 2;
  localparam int ST_HALF = 3;
  localparam int ST_RDVALID = 4;
  localparam int ST_REFUSED = 5;

  localparam int DATA_W = 9;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // ==========================================================
  // pin timing
  localparam int CLK_PS = 4000;
  localparam int STROBE_LOW_NS = 30;
  localparam int STROBE_HIGH_NS = 20;
  localparam int RESET_LOW_NS = 40;
  localparam int ACCESS_NS = 40;
  localparam logic [3:0] STROBE_LOW_CYC = 4'((STROBE_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] STROBE_HIGH_CYC = 4'((STROBE_HIGH_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] RESET_LOW_CYC = 4'((RESET_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] ACCESS_CYC = 4'((ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS);

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_LOW,
    SEQ_RECOVER
  } afc_seq_e;

  typedef enum logic [1:0] {
    OP_PUSH,
    OP_POP,
    OP_RESET,
    OP_REPLAY
  } afc_op_e;

  // strobes, levels and ingress data toward the device
  typedef struct packed {
    logic pushStrobeN;
    logic popStrobeN;
    logic masterResetN;
    logic leadOrReplayN;
    logic chainInN;
    logic [DATA_W-1:0] ingressBus;
    logic ingressOe;
  } afc_pins_s;

  // flags from the device
  typedef struct packed {
    logic emptyFlagN;
    logic fullFlagN;
    logic halfLevelFlagN;
  } afc_flags_s;

endpackage

// ### afc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// three-stage input synchroniser with agreement filter
module afc_sync #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // pins
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] held;
  } afc_sync_s;

  afc_sync_s st;
  afc_sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pinIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      // a change counts only once stages two and three agree
      if (st.s2[i] == st.s3[i]) begin
        next_st.held[i] = st.s3[i];
      end
    end
  end

  // flags idle high (deasserted) from reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign pinOut = st.held;

endmodule
`default_nettype wire

// ### afc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// behavioural buffer device on the far side of the host
module afc_dev_model #(
  parameter int DEPTH = 4
) (
  // pins from the host
  input wire afc_pkg::afc_pins_s pins,
  // answers to the host
  output logic [afc_pkg::DATA_W-1:0] egressBus,
  output var afc_pkg::afc_flags_s flags
);
  logic [afc_pkg::DATA_W-1:0] mem [DEPTH];
  logic [afc_pkg::DATA_W-1:0] lastQ = '0;
  logic popOk = 1'b0;
  int rp = 0;
  int wp = 0;
  int cnt = 0;
  logic wrOwn = 1'b1;
  wire chained = pins.chainInN;
  always @(negedge pins.masterResetN) begin
    rp = 0;
    wp = 0;
    cnt = 0;
    // only the first device of a chain takes data after reset
    wrOwn = !pins.chainInN || !pins.leadOrReplayN;
  end
  // data stored on the rising push edge
  always @(posedge pins.pushStrobeN) if (pins.masterResetN && cnt < DEPTH && wrOwn) begin
    mem[wp] = pins.ingressBus;
    wp = (wp + 1) % DEPTH;
    cnt++;
    // last location written: the write token moves on down the chain
    if (pins.chainInN && wp == 0) wrOwn = 1'b0;
  end
  always @(negedge pins.popStrobeN) begin
    popOk = pins.masterResetN && cnt > 0;
    if (popOk) lastQ = mem[rp];
  end
  always @(posedge pins.popStrobeN) if (popOk) begin
    rp = (rp + 1) % DEPTH;
    cnt--;
    popOk = 1'b0;
  end
  // replay assumes no wrap since reset: fine for short tests
  // reads the pin itself: the chained wire may settle after this edge
  always @(negedge pins.leadOrReplayN) if (pins.masterResetN && !pins.chainInN) begin
    rp = 0;
    cnt = wp;
  end
  // released bus shows the inverse so stale data never matches
  assign egressBus = (!pins.popStrobeN && popOk) ? lastQ : ~lastQ;
  assign flags.emptyFlagN = cnt != 0;
  assign flags.fullFlagN = cnt != DEPTH;
  assign flags.halfLevelFlagN = chained || cnt <= DEPTH / 2;
endmodule
`default_nettype wire

// ### afc_host_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host test: avalon calls against the device model
module afc_host_test;
  localparam int DEPTH = 4;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  afc_pkg::afc_pins_s devPins;
  logic [afc_pkg::DATA_W-1:0] egressBus;
  afc_pkg::afc_flags_s devFlags;
  logic [31:0] rd;
  int n_mismatch = 0;
  int n_compared = 0;
  always #2 clk_sys = ~clk_sys;
  afc_host i_afc_host(.clk_sys(clk_sys), .nrst(nrst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .devPins(devPins),
    .egressBus(egressBus), .devFlags(devFlags));
  afc_dev_model #(.DEPTH(DEPTH)) i_afc_dev_model(.pins(devPins), .egressBus(egressBus),
    .flags(devFlags));
  // ==========================================================
  // report
  task automatic close_out;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  // ==========================================================
  // bus access: held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avsWaitRequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      n_mismatch++;
      close_out();
    end
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  // command spacing covers strobe, recovery and flag sync
  task automatic cmd(input logic [31:0] c);
    bus(1'b1, afc_pkg::REG_CMD, c);
    repeat (40) @(posedge clk_sys);
  endtask
  task automatic stat(input logic [31:0] e);
    bus(1'b0, afc_pkg::REG_STATUS, 32'h0);
    chk("status", e, rd & 32'h2E);
  endtask
  task automatic push(input logic [31:0] d);
    bus(1'b1, afc_pkg::REG_WDATA, d);
    cmd(32'h1);
  endtask
  task automatic pop(input logic [31:0] e);
    cmd(32'h2);
    bus(1'b0, afc_pkg::REG_RDATA, 32'h0);
    chk("rdata", e, rd & 32'h1FF);
  endtask
  // ==========================================================
  // scenarios
  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    cmd(32'h4);
    stat(32'h02);
    for (int i = 0; i < DEPTH; i++) push(32'h100 + i);
    stat(32'h0C);
    cmd(32'h1);
    stat(32'h2C);
    stat(32'h0C);
    for (int i = 0; i < DEPTH; i++) pop(32'h100 + i);
    stat(32'h02);
    cmd(32'h2);
    stat(32'h22);
    cmd(32'h4);
    push(32'h0A5);
    push(32'h15A);
    bus(1'b0, afc_pkg::REG_WDATA, 32'h0);
    chk("wdata", 32'h15A, rd);
    pop(32'h0A5);
    cmd(32'h8);
    pop(32'h0A5);
    pop(32'h15A);
    bus(1'b0, 4'hF, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, afc_pkg::REG_CTRL, 32'h1);
    bus(1'b0, afc_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    cmd(32'h4);
    stat(32'h02);
    for (int i = 0; i < 3; i++) push(32'h1F0 + i);
    stat(32'h00);
    // a device that is not first ignores pushes until handed the token
    bus(1'b1, afc_pkg::REG_CTRL, 32'h3);
    cmd(32'h4);
    push(32'h1AA);
    stat(32'h02);
    close_out();
  end
endmodule
`default_nettype wire
